// ---- cmu_cache_op_unit.sv ----
// Cache maintenance operation unit with its own primary tag arrays and APB registers
// Behaviour
// - address is base plus sign-extended offset
// - virtual cache looks up by effective address
// - physical cache looks up by translated address
// - index operations translate; index uses effective address
// - way and index fields from cache geometry
// - direct-mapped cache selects by index only
// - only load-cause refill or invalid translation faults
// - no alignment fault on any address
// - failed writeback reports cache error fault
// - tag read and write never raise cache error
// - kernel region fault reported with load cause
// - watch comparison fixed off for this instruction
// - bits 17:16 select the target cache
// - bits 20:18 give the operation code
// - instruction index invalidate clears the block
// - dirty data block written back, then invalidated
// - write-through cache simply invalidates indexed block
// - tag read copies tag into tag registers
// - tag write loads tag from tag registers
// - hit invalidate clears block holding address
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cmu_cache_op_unit
	import cmu_pkg::*;
#(
	parameter int CACHE_BYTES = 4096,
	parameter int ASSOC = 2,
	parameter int BYTES_PER_TAG = 32,
	parameter int TAG_HIGH_W = 8
)
(
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Issue from the instruction pipeline
	input wire logic issue_valid,
	output logic issue_ready,
	input wire logic [31:0] issue_instr,
	input wire logic [31:0] issue_base,
	output logic done_valid,
	output logic [2:0] done_fault,
	output logic watch_check_valid,
	output logic [31:0] watch_check_addr,
	// Address translation
	output logic xlat_req,
	output logic [31:0] xlat_vaddr,
	input wire logic xlat_ack,
	input wire logic [31:0] xlat_paddr,
	input wire logic xlat_refill,
	input wire logic xlat_invalid,
	input wire logic xlat_addr_err,
	// Writeback to memory
	output logic mem_req,
	output logic [31:0] mem_addr,
	input wire logic mem_ack,
	input wire logic mem_err
);
	// Geometry
	// field boundaries
	localparam int OFFSET_BIT = $clog2(BYTES_PER_TAG);
	localparam int INDEX_BIT = $clog2(CACHE_BYTES / ASSOC);
	localparam int WAY_W = (ASSOC > 1) ? $clog2(ASSOC) : 1;
	localparam int SET_W = INDEX_BIT - OFFSET_BIT;
	localparam int SETS = 1 << SET_W;
	localparam int ENTRY_W = TAG_HIGH_W + CMU_TAG_W + 2;
	localparam logic [31:0] HIT_MASK = ~((32'h1 << INDEX_BIT) - 32'h1);
	localparam logic [31:0] IDX_MASK = ((32'h1 << INDEX_BIT) - 32'h1) & ~((32'h1 << OFFSET_BIT) - 32'h1);

	// Geometry the logic cannot serve
	if ((1 << OFFSET_BIT) != BYTES_PER_TAG || (1 << $clog2(ASSOC)) != ASSOC || ASSOC < 1 ||
		INDEX_BIT <= OFFSET_BIT || INDEX_BIT < CMU_TAG_LSB || TAG_HIGH_W < 1 || TAG_HIGH_W > 32)
	begin : g_bad_geometry
		$error("cmu_cache_op_unit: unsupported cache geometry");
	end

	// One tag entry: high tag, address tag, dirty, valid
	typedef struct packed {
		logic [TAG_HIGH_W-1:0] tag_hi;
		logic [CMU_TAG_W-1:0] tag;
		logic dirty;
		logic valid;
	} cmu_entry_type;

	// All sequencer and register state
	typedef struct packed {
		cmu_state_type state;
		logic [2:0] op;
		logic [1:0] cache;
		logic [31:0] ea;
		logic [31:0] pa;
		logic [31:0] tag_low;
		logic [31:0] tag_high;
		logic [31:0] control;
		cmu_fault_type fault;
		logic [31:0] wb_addr;
		logic [WAY_W-1:0] wb_way;
		logic [CMU_COUNT_W-1:0] count;
	} cmu_regs_type;

	cmu_regs_type r_q; // Registered state
	cmu_regs_type r_d; // Next state
	// Tag arrays of primary instruction [0] and primary data [1]; no reset, software initialises
	cmu_entry_type tag_mem [2][SETS][ASSOC];
	logic mem_we; // Tag array write strobe
	logic mem_sel; // Cache being written
	logic [SET_W-1:0] mem_set; // Set being written
	logic [ASSOC-1:0] mem_way_mask; // Ways being written
	cmu_entry_type mem_wdata; // Entry written
	logic [SET_W-1:0] cur_set; // Set of the captured address
	logic [WAY_W-1:0] cur_way; // Way of the captured address
	logic cur_dcache; // Target is the data cache
	logic [31:0] look_addr; // Address compared on a hit operation
	cmu_entry_type ways_rd [ASSOC]; // All ways of the current set
	cmu_entry_type sel_rd; // Entry of the addressed way
	logic [ASSOC-1:0] hit_vec; // Ways holding the lookup address
	logic apb_wr; // APB write access phase
	logic implemented; // Combination supported here
	logic [31:0] sext_off; // Sign-extended displacement

	// Field extraction from the captured effective address
	// index taken from the untranslated address
	assign cur_set = r_q.ea[INDEX_BIT-1:OFFSET_BIT];
	// way forced to zero when direct mapped
	assign cur_way = (ASSOC > 1) ? r_q.ea[INDEX_BIT +: WAY_W] : '0;
	assign cur_dcache = r_q.cache[0];
	assign look_addr = cur_dcache ? r_q.pa : r_q.ea;
	assign sext_off = {{(32 - CMU_OFFSET_W){issue_instr[CMU_OFFSET_W-1]}}, issue_instr[CMU_OFFSET_W-1:0]};

	// Read all ways of the addressed set and compare tags
	always_comb
	begin
		for (int w = 0; w < ASSOC; w++)
		begin
			ways_rd[w] = tag_mem[cur_dcache][cur_set][w];
			hit_vec[w] = ways_rd[w].valid && ((({ways_rd[w].tag, {CMU_TAG_LSB{1'b0}}} ^ look_addr) & HIT_MASK) == 32'h0);
		end
		sel_rd = ways_rd[cur_way];
	end

	// Only the two primary caches with the listed codes are built
	// everything else retires as a no-op
	always_comb
	begin
		implemented = 1'b0;
		if (r_q.cache == CMU_CACHE_PRI_INSTR || r_q.cache == CMU_CACHE_PRI_DATA)
		begin
			implemented = (r_q.op == CMU_OP_INDEX_INV) || (r_q.op == CMU_OP_INDEX_LOAD_TAG) ||
				(r_q.op == CMU_OP_INDEX_STORE_TAG) || (r_q.op == CMU_OP_HIT_INV);
		end
	end

	assign apb_wr = psel && penable && pwrite;

	// Sequencer, tag array strobes and register writes
	always_comb
	begin
		r_d = r_q;
		mem_we = 1'b0;
		mem_sel = cur_dcache;
		mem_set = cur_set;
		mem_way_mask = '0;
		mem_way_mask[cur_way] = 1'b1;
		mem_wdata = sel_rd;
		// Software register writes; a hardware tag load below overrides the same cycle
		if (apb_wr)
		begin
			unique case (paddr)
				CMU_REG_TAG_LOW: r_d.tag_low = pwdata;
				CMU_REG_TAG_HIGH: r_d.tag_high = pwdata;
				CMU_REG_CONTROL: r_d.control = pwdata;
				default: ;
			endcase
		end
		unique case (r_q.state)
			CMU_IDLE:
			begin
				if (issue_valid)
				begin
					r_d.ea = issue_base + sext_off;
					r_d.cache = issue_instr[CMU_CACHE_LSB +: 2];
					r_d.op = issue_instr[CMU_OP_LSB +: 3];
					r_d.fault = CMU_FAULT_NONE;
					r_d.state = CMU_XLAT;
				end
			end
			CMU_XLAT:
			begin
				if (xlat_ack)
				begin
					r_d.pa = xlat_paddr;
					// faults only with the load cause
					if (xlat_refill)
					begin
						r_d.fault = CMU_FAULT_TLB_REFILL_LOAD;
						r_d.state = CMU_DONE;
					end
					else if (xlat_invalid)
					begin
						r_d.fault = CMU_FAULT_TLB_INVALID_LOAD;
						r_d.state = CMU_DONE;
					end
					else if (xlat_addr_err)
					begin
						r_d.fault = CMU_FAULT_ADDR_ERR_LOAD;
						r_d.state = CMU_DONE;
					end
					else if (implemented && r_q.control[CMU_CTRL_ENABLE_BIT])
					begin
						r_d.state = CMU_LOOK;
					end
					else
					begin
						r_d.state = CMU_DONE;
					end
				end
			end
			CMU_LOOK:
			begin
				r_d.state = CMU_DONE;
				unique case (r_q.op)
					CMU_OP_INDEX_INV:
					begin
						if (cur_dcache && sel_rd.valid && sel_rd.dirty)
						begin
							// write back to the address named by the tag
							r_d.wb_addr = ({sel_rd.tag, {CMU_TAG_LSB{1'b0}}} & HIT_MASK) | (r_q.ea & IDX_MASK);
							r_d.wb_way = cur_way;
							r_d.state = CMU_WRITEBACK;
						end
						else
						begin
							// clean or write-through block just invalidated
							mem_we = 1'b1;
							mem_wdata.valid = 1'b0;
						end
					end
					CMU_OP_INDEX_LOAD_TAG:
					begin
						// tag copied into the tag registers
						r_d.tag_low = {sel_rd.tag, {(CMU_TAG_LSB - 2){1'b0}}, sel_rd.dirty, sel_rd.valid};
						r_d.tag_high = 32'(sel_rd.tag_hi);
					end
					CMU_OP_INDEX_STORE_TAG:
					begin
						// tag written from the tag registers
						mem_we = 1'b1;
						mem_wdata.tag = r_q.tag_low[31:CMU_TAG_LSB];
						mem_wdata.dirty = r_q.tag_low[CMU_DIRTY_BIT];
						mem_wdata.valid = r_q.tag_low[CMU_VALID_BIT];
						mem_wdata.tag_hi = r_q.tag_high[TAG_HIGH_W-1:0];
					end
					CMU_OP_HIT_INV:
					begin
						// every way holding the address is invalidated
						mem_we = |hit_vec;
						mem_way_mask = hit_vec;
						mem_wdata = '0;
					end
					default: ;
				endcase
			end
			CMU_WRITEBACK:
			begin
				mem_way_mask = '0;
				mem_way_mask[r_q.wb_way] = 1'b1;
				if (mem_ack)
				begin
					r_d.state = CMU_DONE;
					if (mem_err)
					begin
						// failed writeback keeps the line and faults
						r_d.fault = CMU_FAULT_CACHE_ERR;
					end
					else
					begin
						mem_we = 1'b1;
						mem_wdata = '0;
					end
				end
			end
			CMU_DONE:
			begin
				// tag operations never carry a cache error
				if (r_q.op == CMU_OP_INDEX_LOAD_TAG || r_q.op == CMU_OP_INDEX_STORE_TAG)
				begin
					if (r_q.fault == CMU_FAULT_CACHE_ERR)
					begin
						r_d.fault = CMU_FAULT_NONE;
					end
				end
				r_d.count = r_q.count + 1'b1;
				r_d.state = CMU_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r_q <= '{state: CMU_IDLE, op: 3'h0, cache: 2'h0, ea: 32'h0, pa: 32'h0,
				tag_low: CMU_TAG_RESET, tag_high: CMU_TAG_RESET, control: CMU_CONTROL_RESET,
				fault: CMU_FAULT_NONE, wb_addr: 32'h0, wb_way: '0, count: '0};
		end
		else
		begin
			r_q <= r_d;
		end
	end

	// Tag array write port; one set, any mask of ways
	always_ff @(posedge pclk)
	begin
		if (mem_we)
		begin
			for (int w = 0; w < ASSOC; w++)
			begin
				if (mem_way_mask[w])
				begin
					tag_mem[mem_sel][mem_set][w] <= mem_wdata;
				end
			end
		end
	end

	// APB read mux; zero-wait, unmapped offsets answer with an error
	always_comb
	begin
		prdata = 32'h0;
		pslverr = 1'b0;
		unique case (paddr)
			CMU_REG_TAG_LOW: prdata = r_q.tag_low;
			CMU_REG_TAG_HIGH: prdata = r_q.tag_high;
			CMU_REG_CONTROL: prdata = r_q.control;
			CMU_REG_STATUS:
			begin
				prdata[CMU_STAT_BUSY_BIT] = (r_q.state != CMU_IDLE);
				prdata[CMU_STAT_FAULT_LSB +: 3] = r_q.fault;
				prdata[CMU_STAT_COUNT_LSB +: CMU_COUNT_W] = r_q.count;
			end
			default: pslverr = psel && penable;
		endcase
	end
	assign pready = 1'b1;

	// Pipeline and translation handshakes
	assign issue_ready = (r_q.state == CMU_IDLE);
	assign done_valid = (r_q.state == CMU_DONE);
	assign done_fault = r_q.fault;
	// watch comparison held off by a fixed choice
	assign watch_check_valid = done_valid && CMU_WATCH_ON_CACHE_OP;
	assign watch_check_addr = r_q.ea;
	assign xlat_req = (r_q.state == CMU_XLAT);
	assign xlat_vaddr = r_q.ea;
	assign mem_req = (r_q.state == CMU_WRITEBACK);
	assign mem_addr = r_q.wb_addr;
endmodule
`default_nettype wire

// ---- cmu_cache_op_unit_chk.sv ----
// Assertion checker bound to the cache maintenance operation unit
`timescale 1ns/1ps
`default_nettype none
module cmu_cache_op_unit_chk
	import cmu_pkg::*;
#(
	parameter int CACHE_BYTES = 4096,
	parameter int ASSOC = 2,
	parameter int BYTES_PER_TAG = 32,
	parameter int TAG_HIGH_W = 8
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic issue_valid,
	input wire logic issue_ready,
	input wire logic [31:0] issue_instr,
	input wire logic [31:0] issue_base,
	input wire logic done_valid,
	input wire logic [2:0] done_fault,
	input wire logic watch_check_valid,
	input wire logic xlat_req,
	input wire logic [31:0] xlat_vaddr,
	input wire logic xlat_ack,
	input wire logic xlat_refill,
	input wire logic xlat_invalid,
	input wire logic xlat_addr_err,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic mem_ack,
	input wire logic mem_err
);
	localparam int OFF_BIT = $clog2(BYTES_PER_TAG);
	localparam int IDX_BIT = $clog2(CACHE_BYTES / ASSOC);
	// Index bits of a line address, byte offset excluded
	localparam logic [31:0] IDX_MASK = ((32'h1 << IDX_BIT) - 32'h1) & ~((32'h1 << OFF_BIT) - 32'h1);
	logic take;
	logic [31:0] ea_q; // Address of the instruction in flight
	logic [4:0] opc_q; // Its operation and cache fields
	assign take = issue_valid & issue_ready;
	// Capture each instruction as it is taken
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ea_q <= 32'h0;
			opc_q <= 5'h0;
		end
		else if (take)
		begin
			ea_q <= issue_base + {{16{issue_instr[15]}}, issue_instr[15:0]};
			opc_q <= issue_instr[20:16];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ea;
		xlat_req |-> xlat_vaddr == ea_q;
	endproperty
	a_ea: assert property (p_ea) else $error("effective address mismatch");
	property p_watch;
		!watch_check_valid;
	endproperty
	a_watch: assert property (p_watch) else $error("watch check raised");
	property p_refill;
		xlat_ack && xlat_refill |=> done_valid && done_fault == CMU_FAULT_TLB_REFILL_LOAD;
	endproperty
	a_refill: assert property (p_refill) else $error("refill fault not reported");
	property p_aerr;
		xlat_ack && !xlat_refill && !xlat_invalid && xlat_addr_err |=> done_valid && done_fault == CMU_FAULT_ADDR_ERR_LOAD;
	endproperty
	a_aerr: assert property (p_aerr) else $error("address fault not reported");
	property p_tagop;
		xlat_ack && !(xlat_refill | xlat_invalid | xlat_addr_err) &&
			(opc_q[4:2] == CMU_OP_INDEX_LOAD_TAG || opc_q[4:2] == CMU_OP_INDEX_STORE_TAG)
			|=> ##[0:1] (done_valid && done_fault == CMU_FAULT_NONE);
	endproperty
	a_tagop: assert property (p_tagop) else $error("tag operation faulted");
	property p_cerr;
		mem_req && mem_ack && mem_err |=> done_valid && done_fault == CMU_FAULT_CACHE_ERR;
	endproperty
	a_cerr: assert property (p_cerr) else $error("writeback error not reported");
	property p_wb;
		mem_req |-> opc_q == {CMU_OP_INDEX_INV, CMU_CACHE_PRI_DATA} && (mem_addr & IDX_MASK) == (ea_q & IDX_MASK);
	endproperty
	a_wb: assert property (p_wb) else $error("unexpected writeback");
	property p_bound;
		take |-> ##[2:40] done_valid;
	endproperty
	a_bound: assert property (p_bound) else $error("instruction never retired");
endmodule
bind cmu_cache_op_unit cmu_cache_op_unit_chk #(.CACHE_BYTES(CACHE_BYTES), .ASSOC(ASSOC),
	.BYTES_PER_TAG(BYTES_PER_TAG), .TAG_HIGH_W(TAG_HIGH_W)) u_chk (.pclk, .presetn, .issue_valid,
	.issue_ready, .issue_instr, .issue_base, .done_valid, .done_fault, .watch_check_valid, .xlat_req,
	.xlat_vaddr, .xlat_ack, .xlat_refill, .xlat_invalid, .xlat_addr_err, .mem_req, .mem_addr, .mem_ack, .mem_err);
`default_nettype wire

// ---- cmu_cache_op_unit_test.sv ----
// Self-checking bench for the cache maintenance operation unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module cmu_cache_op_unit_test
	import cmu_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, issue_valid = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, issue_instr = 32'h0, issue_base = 32'h0, rd;
	logic [3:0] cfg_dly = 4'h0, cfg_flt = 4'h0; // Far-side latency and faults
	logic pready, pslverr, issue_ready, done_valid, xlat_req, xlat_ack, xlat_refill, xlat_invalid, xlat_addr_err;
	logic mem_req, mem_ack, mem_err, err;
	logic [31:0] prdata, xlat_vaddr, xlat_paddr, mem_addr, seen_maddr;
	logic [2:0] done_fault, flt;
	int compares = 0, miscompares = 0, cycles = 0, n_ret = 0;
	// Operations with no implementation: {op, cache}
	localparam logic [4:0] NOP_TAB [6] = '{5'h02, 5'h03, 5'h0d, 5'h15, 5'h19, 5'h1d};
	cmu_cache_op_unit dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .issue_valid, .issue_ready, .issue_instr, .issue_base, .done_valid, .done_fault,
		.watch_check_valid(), .watch_check_addr(), .xlat_req, .xlat_vaddr, .xlat_ack, .xlat_paddr,
		.xlat_refill, .xlat_invalid, .xlat_addr_err, .mem_req, .mem_addr, .mem_ack, .mem_err);
	cmu_xlat_mem_model u_far (.pclk, .presetn, .cfg_dly, .cfg_flt, .xlat_req, .xlat_vaddr, .xlat_ack,
		.xlat_paddr, .xlat_refill, .xlat_invalid, .xlat_addr_err, .mem_req, .mem_addr, .mem_ack, .mem_err,
		.seen_maddr);
	always #2.5 pclk = ~pclk;
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge pclk)
		if (++cycles == 5000)
			give_verdict(1'b1);
	task give_verdict(input bit hang);
		if (hang)
			miscompares++;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// One APB transfer; read data and error taken at the ready edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Issue one instruction from a kernel unmapped base, latency varies per call
	task op(input logic [1:0] c, input logic [2:0] o, input logic [15:0] off, input logic [3:0] f);
		cfg_flt <= f;
		cfg_dly <= 4'(n_ret % 3);
		@(posedge pclk);
		issue_valid <= 1'b1;
		issue_instr <= {11'h0, o, c, off};
		issue_base <= 32'h8000_1000;
		// Ready and retirement looked at mid-cycle, where they have settled
		@(negedge pclk);
		while (issue_ready !== 1'b1)
			@(negedge pclk);
		@(posedge pclk);
		issue_valid <= 1'b0;
		@(negedge pclk);
		while (done_valid !== 1'b1)
			@(negedge pclk);
		flt = done_fault;
		n_ret++;
	endtask
	task sttag(input logic [1:0] c, input logic [31:0] v);
		apb(1'b1, CMU_REG_TAG_LOW, v);
		op(c, CMU_OP_INDEX_STORE_TAG, 16'hf840, 4'h0);
		`CHK("store fault", CMU_FAULT_NONE, flt)
	endtask
	task ldtag(input logic [1:0] c, input logic [31:0] m, input logic [31:0] e);
		op(c, CMU_OP_INDEX_LOAD_TAG, 16'hf840, 4'h0);
		apb(1'b0, CMU_REG_TAG_LOW, 32'h0);
		`CHK("tag_low", e, rd & m)
	endtask
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CMU_REG_CONTROL, 32'h0);
		`CHK("control", CMU_CONTROL_RESET, rd)
		apb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped", 1'b1, err)
		// way 0 of the used set starts invalid in both caches
		for (int c = 0; c < 2; c++)
		begin
			apb(1'b1, CMU_REG_TAG_LOW, 32'h0);
			op(2'(c), CMU_OP_INDEX_STORE_TAG, 16'hf040, 4'h0);
		end
		apb(1'b1, CMU_REG_TAG_HIGH, 32'h5a);
		sttag(CMU_CACHE_PRI_DATA, 32'h8765_4303);
		apb(1'b1, CMU_REG_TAG_HIGH, 32'h0);
		ldtag(CMU_CACHE_PRI_DATA, 32'hffff_ffff, 32'h8765_4303);
		apb(1'b0, CMU_REG_TAG_HIGH, 32'h0);
		`CHK("tag_high", 32'h5a, rd)
		op(CMU_CACHE_PRI_DATA, CMU_OP_INDEX_INV, 16'hf840, 4'h8);
		`CHK("wb error", CMU_FAULT_CACHE_ERR, flt)
		ldtag(CMU_CACHE_PRI_DATA, 32'hffff_ffff, 32'h8765_4303);
		op(CMU_CACHE_PRI_DATA, CMU_OP_INDEX_INV, 16'hf840, 4'h0);
		`CHK("wb addr", 32'h8765_4040, seen_maddr)
		ldtag(CMU_CACHE_PRI_DATA, 32'h1, 32'h0);
		sttag(CMU_CACHE_PRI_DATA, 32'h1111_1101);
		op(CMU_CACHE_PRI_DATA, CMU_OP_INDEX_INV, 16'hf840, 4'h0);
		`CHK("clean no wb", 32'h8765_4040, seen_maddr)
		ldtag(CMU_CACHE_PRI_DATA, 32'h1, 32'h0);
		// Instruction cache index and hit invalidate at an unaligned address
		for (int i = 0; i < 2; i++)
		begin
			sttag(CMU_CACHE_PRI_INSTR, 32'h8000_0801);
			op(CMU_CACHE_PRI_INSTR, i ? CMU_OP_HIT_INV : CMU_OP_INDEX_INV, 16'hf843, 4'h0);
			`CHK("unaligned", CMU_FAULT_NONE, flt)
			ldtag(CMU_CACHE_PRI_INSTR, 32'h1, 32'h0);
		end
		// Data hit invalidate matches the translated address only
		for (int i = 0; i < 2; i++)
		begin
			sttag(CMU_CACHE_PRI_DATA, i ? 32'ha000_0801 : 32'h8000_0801);
			op(CMU_CACHE_PRI_DATA, CMU_OP_HIT_INV, 16'hf840, 4'h0);
			ldtag(CMU_CACHE_PRI_DATA, 32'h1, i ? 32'h0 : 32'h1);
		end
		for (int i = 0; i < 3; i++)
		begin
			op(CMU_CACHE_PRI_DATA, CMU_OP_INDEX_STORE_TAG, 16'hf840, 4'(1 << i));
			`CHK("xlat fault", 3'(i + 1), flt)
		end
		sttag(CMU_CACHE_PRI_DATA, 32'h8765_4303);
		for (int i = 0; i < 6; i++)
		begin
			op(NOP_TAB[i][1:0], NOP_TAB[i][4:2], 16'hf840, 4'h0);
			`CHK("no-op fault", CMU_FAULT_NONE, flt)
		end
		// Disabled unit retires a dirty index invalidate untouched
		apb(1'b1, CMU_REG_CONTROL, 32'h0);
		op(CMU_CACHE_PRI_DATA, CMU_OP_INDEX_INV, 16'hf840, 4'h0);
		`CHK("disabled fault", CMU_FAULT_NONE, flt)
		apb(1'b1, CMU_REG_CONTROL, CMU_CONTROL_RESET);
		ldtag(CMU_CACHE_PRI_DATA, 32'hffff_ffff, 32'h8765_4303);
		`CHK("no-op no wb", 32'h8765_4040, seen_maddr)
		apb(1'b0, CMU_REG_STATUS, 32'h0);
		`CHK("retired", 16'(n_ret), rd[31:16])
		give_verdict(1'b0);
	end
endmodule
`default_nettype wire

// ---- cmu_pkg.sv ----
// Constants and types shared by the cache maintenance operation unit
package cmu_pkg;
	// Instruction field positions
	localparam int CMU_OFFSET_W = 16;
	localparam int CMU_CACHE_LSB = 16;
	localparam int CMU_OP_LSB = 18;
	// Target cache selector codes
	localparam logic [1:0] CMU_CACHE_PRI_INSTR = 2'h0;
	localparam logic [1:0] CMU_CACHE_PRI_DATA = 2'h1;
	localparam logic [1:0] CMU_CACHE_TERTIARY = 2'h2;
	localparam logic [1:0] CMU_CACHE_SECONDARY = 2'h3;
	// Operation code field values
	localparam logic [2:0] CMU_OP_INDEX_INV = 3'h0;
	localparam logic [2:0] CMU_OP_INDEX_LOAD_TAG = 3'h1;
	localparam logic [2:0] CMU_OP_INDEX_STORE_TAG = 3'h2;
	localparam logic [2:0] CMU_OP_IMPL_SPECIFIC = 3'h3;
	localparam logic [2:0] CMU_OP_HIT_INV = 3'h4;
	// Tag-low register layout
	localparam int CMU_VALID_BIT = 0;
	localparam int CMU_DIRTY_BIT = 1;
	localparam int CMU_TAG_LSB = 8;
	localparam int CMU_TAG_W = 32 - CMU_TAG_LSB;
	// APB register byte offsets
	localparam logic [7:0] CMU_REG_TAG_LOW = 8'h00;
	localparam logic [7:0] CMU_REG_TAG_HIGH = 8'h04;
	localparam logic [7:0] CMU_REG_CONTROL = 8'h08;
	localparam logic [7:0] CMU_REG_STATUS = 8'h0c;
	// Reset values
	localparam logic [31:0] CMU_TAG_RESET = 32'h0000_0000;
	localparam logic [31:0] CMU_CONTROL_RESET = 32'h0000_0001;
	// Control bit: operations enabled
	localparam int CMU_CTRL_ENABLE_BIT = 0;
	// Status fields
	localparam int CMU_STAT_BUSY_BIT = 0;
	localparam int CMU_STAT_FAULT_LSB = 4;
	localparam int CMU_STAT_COUNT_LSB = 16;
	localparam int CMU_COUNT_W = 16;
	// Data watch comparison is never applied to this instruction
	localparam logic CMU_WATCH_ON_CACHE_OP = 1'b0;
	// Fault report codes
	typedef enum logic [2:0] {
		CMU_FAULT_NONE = 3'h0,
		CMU_FAULT_TLB_REFILL_LOAD = 3'h1,
		CMU_FAULT_TLB_INVALID_LOAD = 3'h2,
		CMU_FAULT_ADDR_ERR_LOAD = 3'h3,
		CMU_FAULT_CACHE_ERR = 3'h4
	} cmu_fault_type;
	// Sequencer states
	typedef enum logic [2:0] {
		CMU_IDLE,
		CMU_XLAT,
		CMU_LOOK,
		CMU_WRITEBACK,
		CMU_DONE
	} cmu_state_type;
endpackage

// ---- cmu_xlat_mem_model.sv ----
// Translation and writeback memory responder beside the maintenance unit
`timescale 1ns/1ps
`default_nettype none
module cmu_xlat_mem_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] cfg_dly,
	input wire logic [3:0] cfg_flt,
	input wire logic xlat_req,
	input wire logic [31:0] xlat_vaddr,
	output logic xlat_ack,
	output logic [31:0] xlat_paddr,
	output logic xlat_refill,
	output logic xlat_invalid,
	output logic xlat_addr_err,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	output logic mem_ack,
	output logic mem_err,
	output logic [31:0] seen_maddr
);
	logic [3:0] wait_q; // Cycles the open request has waited
	logic ack;
	logic [31:0] pa;
	assign ack = wait_q == cfg_dly;
	// Physical page differs from the virtual one so physical lookups show
	assign pa = xlat_vaddr ^ 32'h2000_0000;
	assign xlat_ack = xlat_req & ack;
	// Outside an answer the lines carry inverted values, never stale ones
	assign xlat_paddr = xlat_ack ? pa : ~pa;
	assign {xlat_addr_err, xlat_invalid, xlat_refill} = xlat_ack ? cfg_flt[2:0] : ~cfg_flt[2:0];
	assign mem_ack = mem_req & ack;
	assign mem_err = mem_ack ? cfg_flt[3] : ~cfg_flt[3];
	// Wait counter and record of the last writeback address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_q <= 4'h0;
			seen_maddr <= 32'h0;
		end
		else
		begin
			wait_q <= ((xlat_req | mem_req) & !ack) ? wait_q + 4'h1 : 4'h0;
			if (mem_ack)
				seen_maddr <= mem_addr;
		end
	end
endmodule
`default_nettype wire
